// ### logic/nfc_bus_cycle.sv
// One flash bus cycle engine: write or read with strobe timing on the parallel pins.
`timescale 1ns/1ps
module nfc_bus_cycle (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [23:0] addrIn,
  input  wire logic [15:0] dataIn,
  output logic             busy,
  output logic             done,
  output logic [15:0]      dataOut,
  output logic [23:0]      flAddr,
  output logic             flCs,
  output logic             flOe_n,
  output logic             flWe_n,
  output logic [15:0]      flDqOut,
  output logic             flDqOe,
  input  wire logic [15:0] flDqIn
);
  logic [5:0] cnt;
  logic [1:0] phase;
  logic       wr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= 2'h0;
      cnt     <= 6'h00;
      wr      <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      dataOut <= 16'h0000;
      flAddr  <= 24'h000000;
      flCs    <= 1'b0;
      flOe_n  <= 1'b1;
      flWe_n  <= 1'b1;
      flDqOut <= 16'h0000;
      flDqOe  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (phase)
        2'h0: begin
          if (start) begin
            phase   <= 2'h1;
            busy    <= 1'b1;
            wr      <= isWrite;
            flAddr  <= addrIn;
            flDqOut <= dataIn;
            flDqOe  <= isWrite;
            flCs    <= 1'b1;
            flWe_n  <= !isWrite;
            flOe_n  <= isWrite;
            cnt     <= 6'(nfc_pkg::STROBE_CYC);
          end
        end
        2'h1: begin
          if (cnt == 6'h01) begin
            if (!wr) begin
              dataOut <= flDqIn;
            end
            flWe_n <= 1'b1;
            flOe_n <= 1'b1;
            phase  <= 2'h2;
            cnt    <= 6'(nfc_pkg::RECOVER_CYC);
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        2'h2: begin
          flDqOe <= 1'b0;
          flCs   <= 1'b0;
          if (cnt == 6'h01) begin
            phase <= 2'h0;
            busy  <= 1'b0;
            done  <= 1'b1;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        default: phase <= 2'h0;
      endcase
    end
  end

  chk_strobe_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(!flWe_n && !flOe_n)) else $error("Write and output enable both active.");
  chk_write_drives: assert property (@(posedge clk) disable iff (!rst_n)
    !flWe_n |-> flDqOe) else $error("Write strobe without data drive.");
endmodule : nfc_bus_cycle

// ### logic/nfc_flash_host.sv
// APB-controlled host that programs, polls, suspends and resumes an asynchronous NOR flash.
// Summary of operation
// - Host masks reserved extended status bits 6 to 0 when polling.
// - Program: write 40H to target, then data to same address.
// - After program, host polls status bit 7 until ready.
// - Host writes FFH to return to array read before reading memory.
// - Full error check after each program or after a series.
// - Host issues clear-status after an error before any retry; the host sends 50H only on OP_CLEAR and does not block a retry.
// - Suspend: write B0H anywhere, poll bit 7 until ready.
// - While suspended host may read array after FFH or program.
// - Write D0H anywhere to resume the suspended erase.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module nfc_flash_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic [23:0]      flAddr,
  output logic             chip_select_0,
  output logic             flOe_n,
  output logic             flWe_n,
  output logic [15:0]      flDqOut,
  output logic             flDqOe,
  input  wire logic [15:0] flDqIn,
  input  wire logic        completion_indicator,
  output logic             reset_powerdown_n
);
  logic [7:0]  ctrl;
  logic [23:0] addrReg;
  logic [15:0] wdataReg;
  logic [15:0] rdataReg;
  logic [7:0]  status_reg;
  logic [7:0]  extended_status;
  logic [3:0]  irqStat;
  logic [3:0]  irqMask;
  logic        opBusy;
  logic        errSeen;
  nfc_pkg::nfc_state_t state;
  logic [2:0]  op;
  logic        cycStart;
  logic        cycWrite;
  logic [23:0] cycAddr;
  logic [15:0] cycData;
  logic        cycBusy;
  logic        cycDone;
  logic [15:0] cycRd;
  logic        indPrev;
  logic [3:0]  evt;
  logic        apbWr;
  logic        apbRd;
  logic        busCs;

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;

  nfc_bus_cycle u_cycle (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (cycStart),
    .isWrite (cycWrite),
    .addrIn  (cycAddr),
    .dataIn  (cycData),
    .busy    (cycBusy),
    .done    (cycDone),
    .dataOut (cycRd),
    .flAddr  (flAddr),
    .flCs    (busCs),
    .flOe_n  (flOe_n),
    .flWe_n  (flWe_n),
    .flDqOut (flDqOut),
    .flDqOe  (flDqOe),
    .flDqIn  (flDqIn)
  );
  assign chip_select_0 = busCs;

  // APB register writes; command launch is accepted only when idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= nfc_pkg::CTRL_RESET;
      addrReg  <= 24'h000000;
      wdataReg <= 16'h0000;
      irqMask  <= nfc_pkg::MASK_RESET[3:0];
    end else if (apbWr) begin
      unique case (paddr)
        nfc_pkg::CTRL_OFF:  ctrl     <= pwdata[7:0];
        nfc_pkg::ADDR_OFF:  addrReg  <= pwdata[23:0];
        nfc_pkg::WDATA_OFF: wdataReg <= pwdata[15:0];
        nfc_pkg::MASK_OFF:  irqMask  <= pwdata[3:0];
        default:            ctrl     <= ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_powerdown_n <= 1'b0;
    end else begin
      reset_powerdown_n <= !ctrl[nfc_pkg::CTRL_PWRDN];
    end
  end

  // APB read mux, one wait-free access phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (apbRd) begin
        unique case (paddr)
          nfc_pkg::CTRL_OFF:  prdata <= {24'h000000, ctrl};
          nfc_pkg::ADDR_OFF:  prdata <= {8'h00, addrReg};
          nfc_pkg::WDATA_OFF: prdata <= {16'h0000, wdataReg};
          nfc_pkg::STAT_OFF:  prdata <= {13'h0000, errSeen, opBusy, completion_indicator,
                                         extended_status, status_reg};
          nfc_pkg::RDATA_OFF: prdata <= {16'h0000, rdataReg};
          nfc_pkg::IRQ_OFF:   prdata <= {28'h0000000, irqStat};
          nfc_pkg::MASK_OFF:  prdata <= {28'h0000000, irqMask};
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Sequencer: issues flash commands and polls status.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= nfc_pkg::ST_IDLE;
      op              <= 3'h0;
      opBusy          <= 1'b0;
      cycStart        <= 1'b0;
      cycWrite        <= 1'b0;
      cycAddr         <= 24'h000000;
      cycData         <= 16'h0000;
      status_reg      <= 8'h00;
      extended_status <= 8'h00;
      rdataReg        <= 16'h0000;
      errSeen         <= 1'b0;
      evt             <= 4'h0;
    end else begin
      cycStart <= 1'b0;
      evt      <= 4'h0;
      unique case (state)
        nfc_pkg::ST_IDLE: begin
          if (apbWr && paddr == nfc_pkg::CTRL_OFF && pwdata[2:0] != 3'h0) begin
            op       <= pwdata[2:0];
            opBusy   <= 1'b1;
            cycStart <= 1'b1;
            cycWrite <= 1'b1;
            cycAddr  <= addrReg;
            state    <= nfc_pkg::ST_CMD;
            unique case (pwdata[2:0])
              nfc_pkg::OP_PROGRAM: cycData <= {8'h00, nfc_pkg::FL_PROGRAM_SETUP};
              nfc_pkg::OP_READ:    cycData <= {8'h00, nfc_pkg::FL_READ_ARRAY};
              nfc_pkg::OP_SUSPEND: cycData <= {8'h00, nfc_pkg::FL_SUSPEND};
              nfc_pkg::OP_RESUME:  cycData <= {8'h00, nfc_pkg::FL_RESUME};
              nfc_pkg::OP_CLEAR:   cycData <= {8'h00, nfc_pkg::FL_CLEAR_STATUS};
              nfc_pkg::OP_XSTAT:   cycData <= {8'h00, nfc_pkg::FL_BUFFER_WRITE};
              default:             cycData <= {8'h00, nfc_pkg::FL_READ_STATUS};
            endcase
          end
        end
        nfc_pkg::ST_CMD: begin
          if (cycDone) begin
            unique case (op)
              nfc_pkg::OP_PROGRAM: begin
                cycStart <= 1'b1;
                cycData  <= wdataReg;
                state    <= nfc_pkg::ST_DATA;
              end
              nfc_pkg::OP_READ: begin
                cycStart <= 1'b1;
                cycWrite <= 1'b0;
                state    <= nfc_pkg::ST_READ;
              end
              nfc_pkg::OP_CLEAR, nfc_pkg::OP_RESUME: begin
                if (op == nfc_pkg::OP_CLEAR) begin
                  errSeen <= 1'b0;
                  status_reg[nfc_pkg::SR_PROGERR] <= 1'b0;
                  status_reg[nfc_pkg::SR_VOLTERR] <= 1'b0;
                  status_reg[nfc_pkg::SR_PROTECT] <= 1'b0;
                end
                state <= nfc_pkg::ST_DONE;
              end
              default: begin
                cycStart <= 1'b1;
                cycWrite <= 1'b0;
                state    <= nfc_pkg::ST_POLL;
              end
            endcase
          end
        end
        nfc_pkg::ST_DATA: begin
          if (cycDone) begin
            cycStart <= 1'b1;
            cycWrite <= 1'b0;
            state    <= nfc_pkg::ST_POLL;
          end
        end
        nfc_pkg::ST_POLL: begin
          // Each new read toggles output enable, which refreshes status.
          if (cycDone) begin
            if (op == nfc_pkg::OP_XSTAT) begin
              extended_status <= cycRd[7:0] & nfc_pkg::XSR_KEEP_MASK;
              if (cycRd[nfc_pkg::XSR_AVAIL]) begin
                state <= nfc_pkg::ST_DONE;
              end else begin
                cycStart <= 1'b1;
              end
            end else if (cycRd[nfc_pkg::SR_READY]) begin
              status_reg <= {1'b1, cycRd[6:0] & nfc_pkg::SR_KEEP_MASK[6:0]};
              state      <= nfc_pkg::ST_CHECK;
            end else begin
              status_reg <= {1'b0, status_reg[6:0]};
              cycStart   <= 1'b1;
            end
          end
        end
        nfc_pkg::ST_CHECK: begin
          // Error check either per program or deferred by software.
          if (ctrl[nfc_pkg::CTRL_CHECK] || op != nfc_pkg::OP_PROGRAM) begin
            if (status_reg[nfc_pkg::SR_PROGERR] || status_reg[nfc_pkg::SR_VOLTERR] ||
                status_reg[nfc_pkg::SR_PROTECT]) begin
              errSeen <= 1'b1;
              evt[nfc_pkg::IRQ_ERR] <= 1'b1;
            end
          end
          if (op == nfc_pkg::OP_SUSPEND && status_reg[nfc_pkg::SR_SUSP]) begin
            evt[nfc_pkg::IRQ_SUSP] <= 1'b1;
          end
          state <= nfc_pkg::ST_DONE;
        end
        nfc_pkg::ST_READ: begin
          if (cycDone) begin
            rdataReg <= cycRd;
            state    <= nfc_pkg::ST_DONE;
          end
        end
        nfc_pkg::ST_DONE: begin
          opBusy <= 1'b0;
          evt[nfc_pkg::IRQ_DONE] <= 1'b1;
          state  <= nfc_pkg::ST_IDLE;
        end
        default: state <= nfc_pkg::ST_IDLE;
      endcase
      // Indicator release: open-drain pin pulled high externally when done.
      if (completion_indicator && !indPrev) begin
        evt[nfc_pkg::IRQ_IND] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indPrev <= 1'b1;
    end else begin
      indPrev <= completion_indicator;
    end
  end

  // Sticky interrupt status, write one to clear, set wins.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          irqStat[gi] <= 1'b0;
        end else if (evt[gi]) begin
          irqStat[gi] <= 1'b1;
        end else if (apbWr && paddr == nfc_pkg::IRQ_OFF && pwdata[gi]) begin
          irqStat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  chk_setup_then_data: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nfc_pkg::ST_CMD && cycDone && op == nfc_pkg::OP_PROGRAM)
    |=> cycStart && cycData == wdataReg) else $error("Program data not sent.");
  chk_poll_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nfc_pkg::ST_POLL && cycDone && !cycRd[nfc_pkg::SR_READY] &&
     op != nfc_pkg::OP_XSTAT) |=> cycStart && state == nfc_pkg::ST_POLL)
    else $error("Busy status did not repoll.");
  chk_mask_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (status_reg & ~nfc_pkg::SR_KEEP_MASK & 8'h7F) == 8'h00)
    else $error("Reserved status bits kept.");
  chk_xsr_mask: assert property (@(posedge clk) disable iff (!rst_n)
    extended_status[6:0] == 7'h00) else $error("Reserved extended bits kept.");
  chk_error_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nfc_pkg::ST_CHECK && status_reg[nfc_pkg::SR_PROGERR] &&
     (ctrl[nfc_pkg::CTRL_CHECK] || op != nfc_pkg::OP_PROGRAM)) |=> errSeen)
    else $error("Error not flagged.");
  chk_error_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (errSeen && !(state == nfc_pkg::ST_CMD && op == nfc_pkg::OP_CLEAR)) |=> errSeen)
    else $error("Error flag dropped without clear.");
  chk_read_after_ff: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nfc_pkg::ST_READ) |-> op == nfc_pkg::OP_READ && cycData[7:0] == 8'hFF)
    else $error("Array read without read-array command.");
  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    |(irqStat & irqMask) |=> irq) else $error("Interrupt not raised.");
  chk_suspend_evt: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nfc_pkg::ST_CHECK && op == nfc_pkg::OP_SUSPEND && status_reg[6])
    |-> ##2 irqStat[nfc_pkg::IRQ_SUSP] [*2]) else $error("Suspend event lost.");
  cov_program: cover property (@(posedge clk) state == nfc_pkg::ST_DATA);
  cov_suspend: cover property (@(posedge clk) evt[nfc_pkg::IRQ_SUSP]);
  cov_error: cover property (@(posedge clk) evt[nfc_pkg::IRQ_ERR]);
  cov_read: cover property (@(posedge clk) state == nfc_pkg::ST_READ && cycDone);
endmodule : nfc_flash_host

// ### pkg/nfc_pkg.sv
// Package holding register map, flash codes, status fields and bus timing for the flash host.
package nfc_pkg;
  // APB register byte offsets.
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADDR_OFF   = 8'h04;
  localparam logic [7:0] WDATA_OFF  = 8'h08;
  localparam logic [7:0] STAT_OFF   = 8'h0C;
  localparam logic [7:0] RDATA_OFF  = 8'h10;
  localparam logic [7:0] IRQ_OFF    = 8'h14;
  localparam logic [7:0] MASK_OFF   = 8'h18;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Command codes written into CTRL[2:0].
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_READ    = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME  = 3'h4;
  localparam logic [2:0] OP_CLEAR   = 3'h5;
  localparam logic [2:0] OP_XSTAT   = 3'h6;
  localparam int         CTRL_CHECK = 3;
  localparam int         CTRL_PWRDN = 4;
  // Flash command bytes.
  localparam logic [7:0] FL_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] FL_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] FL_SUSPEND       = 8'hB0;
  localparam logic [7:0] FL_RESUME        = 8'hD0;
  localparam logic [7:0] FL_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] FL_READ_STATUS   = 8'h70;
  localparam logic [7:0] FL_BUFFER_WRITE  = 8'hE8;
  // Status field positions.
  localparam int SR_READY   = 7;
  localparam int SR_SUSP    = 6;
  localparam int SR_PROGERR = 4;
  localparam int SR_VOLTERR = 3;
  localparam int SR_PROTECT = 1;
  localparam int XSR_AVAIL  = 7;
  localparam logic [7:0] SR_KEEP_MASK  = 8'h5A;
  localparam logic [7:0] XSR_KEEP_MASK = 8'h80;
  // Interrupt bits: done, error, suspended, completion indicator released.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_SUSP = 2;
  localparam int IRQ_IND  = 3;
  // Bus timing: strobe width and recovery, least times rounded up.
  localparam int CLK_NS     = 4;
  localparam int STROBE_NS  = 70;
  localparam int RECOVER_NS = 30;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CMD     = 4'b0001,
    ST_DATA    = 4'b0010,
    ST_POLL    = 4'b0011,
    ST_CHECK   = 4'b0100,
    ST_ARRAY   = 4'b0101,
    ST_READ    = 4'b0110,
    ST_DONE    = 4'b0111
  } nfc_state_t;
endpackage : nfc_pkg

// ### tb/nfc_flash_host_bench.sv
// Self-checking bench for the APB flash host with a device model on its pins.
`timescale 1ns/1ps
`define CHECK_EQ(name, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("BAD %s expected %h seen %h", name, exp, got); \
    end \
  end
module nfc_flash_host_bench;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic [2:0]  fail;
    logic [7:0]  expSr;
  } nfc_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, chip_select_0, flOe_n, flWe_n, flDqOe;
  logic        reset_powerdown_n, stsPullLow, bad;
  logic [23:0] flAddr;
  logic [15:0] flDqOut, flDqIn;
  logic [2:0]  failCode = 3'h0;
  logic        eraseActive = 1'b0;
  int          fails = 0, n_compared = 0, cycles = 0;
  wire logic   stsPin = ~stsPullLow;
  nfc_row_t    rows [5] = '{
    '{24'h000003, 16'hA5C3, 3'h0, 8'h80},
    '{24'h00000C, 16'h0F0F, 3'h1, 8'h88},
    '{24'h000005, 16'h1234, 3'h2, 8'h82},
    '{24'h000007, 16'hFFFE, 3'h4, 8'h90},
    '{24'h00000F, 16'h0001, 3'h0, 8'h80}};

  always #2 clk = ~clk;

  nfc_flash_host i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .flAddr(flAddr), .chip_select_0(chip_select_0),
    .flOe_n(flOe_n), .flWe_n(flWe_n), .flDqOut(flDqOut), .flDqOe(flDqOe),
    .flDqIn(flDqIn), .completion_indicator(stsPin), .reset_powerdown_n(reset_powerdown_n));

  nfc_flash_model i_flash (.clk(clk), .reset_powerdown_n(reset_powerdown_n),
    .flAddr(flAddr), .chip_select_0(chip_select_0), .flOe_n(flOe_n), .flWe_n(flWe_n),
    .flDqOut(flDqOut), .failCode(failCode), .eraseActive(eraseActive),
    .flDqIn(flDqIn), .stsPullLow(stsPullLow));

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      final_report();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd  = prdata;
    bad = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_op(input logic [31:0] ctrl);
    int n = 0;
    apb(1'b1, nfc_pkg::CTRL_OFF, ctrl);
    do begin
      apb(1'b0, nfc_pkg::STAT_OFF, 32'h0);
      n++;
    end while (rd[17] !== 1'b0 && n < 400);
    if (n >= 400) fails++;
  endtask : run_op

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, nfc_pkg::MASK_OFF, 32'h0000000F);
    foreach (rows[i]) begin
      failCode <= rows[i].fail;
      apb(1'b1, nfc_pkg::ADDR_OFF, {8'h00, rows[i].addr});
      apb(1'b1, nfc_pkg::WDATA_OFF, {16'h0000, rows[i].data});
      run_op(32'h9);
      `CHECK_EQ("status", rows[i].expSr, rd[7:0])
      `CHECK_EQ("errSeen", rows[i].fail != 3'h0, rd[18])
      `CHECK_EQ("xstat", 8'h00, rd[15:8])
      apb(1'b0, nfc_pkg::IRQ_OFF, 32'h0);
      `CHECK_EQ("irq", 1'b1, irq)
      `CHECK_EQ("indRel", 1'b1, rd[3])
      apb(1'b1, nfc_pkg::IRQ_OFF, 32'hFFFFFFFF);
      if (rows[i].fail != 3'h0) begin
        run_op(32'h5);
        `CHECK_EQ("cleared", 9'h080, {rd[18], rd[7:0]})
      end else begin
        run_op(32'h2);
        apb(1'b0, nfc_pkg::RDATA_OFF, 32'h0);
        `CHECK_EQ("rdata", rows[i].data, rd[15:0])
      end
    end
    failCode <= 3'h1;
    run_op(32'h1);
    failCode <= 3'h4;
    run_op(32'h1);
    `CHECK_EQ("sticky", 8'h98, rd[7:0])
    failCode <= 3'h0;
    run_op(32'h5);
    eraseActive <= 1'b1;
    run_op(32'h3);
    `CHECK_EQ("susp", 1'b1, rd[6])
    `CHECK_EQ("stsIdle", 1'b1, rd[16])
    run_op(32'h1);
    `CHECK_EQ("suspProg", 8'hC0, rd[7:0])
    run_op(32'h4);
    `CHECK_EQ("resumed", 1'b0, i_flash.susp)
    eraseActive <= 1'b0;
    run_op(32'h3);
    `CHECK_EQ("eraseDone", 1'b0, rd[6])
    apb(1'b0, nfc_pkg::IRQ_OFF, 32'h0);
    `CHECK_EQ("suspIrq", 1'b1, rd[2])
    run_op(32'h6);
    `CHECK_EQ("xAvail", 8'h80, rd[15:8])
    apb(1'b1, nfc_pkg::IRQ_OFF, 32'hFFFFFFFF);
    apb(1'b1, nfc_pkg::MASK_OFF, 32'h0);
    run_op(32'h5);
    `CHECK_EQ("masked", 1'b0, irq)
    apb(1'b1, nfc_pkg::MASK_OFF, 32'h1);
    repeat (2) @(negedge clk);
    `CHECK_EQ("unmasked", 1'b1, irq)
    apb(1'b1, nfc_pkg::IRQ_OFF, 32'h1);
    repeat (2) @(negedge clk);
    `CHECK_EQ("irqClr", 1'b0, irq)
    apb(1'b0, 8'h1C, 32'h0);
    `CHECK_EQ("unmapped", 33'h100000000, {bad, rd})
    apb(1'b1, nfc_pkg::CTRL_OFF, 32'h10);
    repeat (2) @(negedge clk);
    `CHECK_EQ("pdPin", 2'b01, {reset_powerdown_n, stsPin})
    apb(1'b1, nfc_pkg::CTRL_OFF, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHECK_EQ("rstPin", 2'b01, {reset_powerdown_n, stsPin})
    rst_n <= 1'b1;
    apb(1'b0, nfc_pkg::MASK_OFF, 32'h0);
    `CHECK_EQ("maskRst", {24'h0, nfc_pkg::MASK_RESET}, rd)
    apb(1'b0, nfc_pkg::CTRL_OFF, 32'h0);
    `CHECK_EQ("ctrlRst", {24'h0, nfc_pkg::CTRL_RESET}, rd)
    final_report();
  end
endmodule : nfc_flash_host_bench

// ### tb/nfc_flash_model.sv
// Behavioural flash device model answering the host's parallel bus pins.
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int BUSY_CYC = 40
) (
  input  wire logic        clk,
  input  wire logic        reset_powerdown_n,
  input  wire logic [23:0] flAddr,
  input  wire logic        chip_select_0,
  input  wire logic        flOe_n,
  input  wire logic        flWe_n,
  input  wire logic [15:0] flDqOut,
  input  wire logic [2:0]  failCode,
  input  wire logic        eraseActive,
  output logic      [15:0] flDqIn,
  output logic             stsPullLow
);
  logic [15:0] mem [16];
  logic [15:0] dout = 16'h0000;
  logic [7:0]  busyCnt;
  logic [1:0]  mode;
  logic        prevWe, pendProg, susp, progErr, voltErr, protErr;
  wire  logic  ready = (busyCnt == 8'h00);
  wire  logic [7:0] sr = {ready, susp & ready, 1'b0, progErr, voltErr, 1'b1, protErr, 1'b1};

  initial foreach (mem[i]) mem[i] = 16'hFFFF;

  always @(posedge clk or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      {busyCnt, mode, pendProg, susp, progErr, voltErr, protErr} <= '0;
      prevWe <= 1'b1;
    end else begin
      prevWe <= flWe_n;
      if (busyCnt != 8'h00) busyCnt <= busyCnt - 8'h01;
      if (chip_select_0 && !prevWe && flWe_n) begin
        mode <= 2'd1;
        if (pendProg) begin
          pendProg <= 1'b0;
          busyCnt  <= BUSY_CYC[7:0];
          voltErr  <= voltErr | failCode[0];
          protErr  <= protErr | failCode[1];
          progErr  <= progErr | failCode[2];
          if (failCode == 3'h0) mem[flAddr[3:0]] <= flDqOut;
        end else begin
          case (flDqOut[7:0])
            8'h40: pendProg <= 1'b1;
            8'hFF: mode <= 2'd0;
            8'hB0: begin
              busyCnt <= 8'h08;
              susp    <= eraseActive;
            end
            8'hD0: susp <= 1'b0;
            8'h50: {progErr, voltErr, protErr} <= 3'b000;
            8'hE8: begin
              busyCnt <= 8'h04;
              mode    <= 2'd2;
            end
            default: ;
          endcase
        end
      end
    end
  end

  always @(negedge flOe_n) begin
    case (mode)
      2'd0: dout = mem[flAddr[3:0]];
      2'd2: dout = {8'h00, ready, 7'h7F};
      default: dout = {8'h00, sr};
    endcase
  end

  assign flDqIn = (chip_select_0 && !flOe_n) ? dout : ~dout;
  assign stsPullLow = reset_powerdown_n && !ready;
endmodule : nfc_flash_model
